//--- hdl/fir_cfg_pkg.sv
`default_nettype none
package fir_cfg_pkg;

    // ==============================================================
    // Widths.
    localparam int ADDR_W     = 16;
    localparam int DATA_W     = 32;
    localparam int SAMP_W     = 12;
    localparam int COEF_W     = 12;
    localparam int GAIN_W     = 5;
    localparam int CFG_W      = 7;
    localparam int IDX_W      = 14;
    localparam int FIFO_DEPTH = 8;

    // ==============================================================
    // Register indices; the byte address is four times the index.
    localparam logic [IDX_W-1:0] IDX_GAIN_B1_DUAL   = 14'h0353;
    localparam logic [IDX_W-1:0] IDX_GAIN_A0_SINGLE = 14'h0354;
    localparam logic [IDX_W-1:0] IDX_GAIN_A1_SINGLE = 14'h0355;
    localparam logic [IDX_W-1:0] IDX_GAIN_B0_SINGLE = 14'h0356;
    localparam logic [IDX_W-1:0] IDX_GAIN_B1_SINGLE = 14'h0357;
    localparam logic [IDX_W-1:0] IDX_FIR_CFG        = 14'h0400;
    localparam logic [IDX_W-1:0] IDX_LINK_CTRL      = 14'h0401;
    localparam logic [IDX_W-1:0] IDX_STATUS         = 14'h0402;

    // ==============================================================
    // Field positions and reset values of the filter configuration and gain trims.
    localparam int CFG_SHARE_BIT = 6;
    localparam int CFG_MERGE_BIT = 5;
    localparam int CFG_SCW_MSB   = 4;
    localparam int CFG_SCW_LSB   = 2;
    localparam int CFG_MODE_MSB  = 1;
    localparam int CFG_MODE_LSB  = 0;
    localparam logic [CFG_W-1:0]  CFG_RESET  = 7'h00;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 5'h00;
    localparam logic [1:0]        MODE_OFF   = 2'h0;
    localparam logic [1:0]        MODE_ON    = 2'h2;

    // ==============================================================
    // Fixed-point scaling: side LSB is 2^(weight-16), centre 2^-11.
    localparam int SIDE_EXP     = 16;
    localparam int CENTER_SHIFT = 5;

endpackage : fir_cfg_pkg
`default_nettype wire

//--- hdl/sample_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wptr;
        logic [AW-1:0]               rptr;
        logic [AW:0]                 count;
    } fifo_t;

    fifo_t s_r;
    fifo_t s_nxt;
    logic  push;
    logic  pop;

    // ==============================================================
    // Handshakes come straight from the occupancy count.
    assign in_ready  = (s_r.count != (AW+1)'(DEPTH));
    assign out_valid = (s_r.count != '0);
    assign out_data  = s_r.mem[s_r.rptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Next state: write at the tail, read at the head.
    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wptr] = in_data;
            s_nxt.wptr          = s_r.wptr + 1'b1;
        end
        if (pop) begin
            s_nxt.rptr = s_r.rptr + 1'b1;
        end
        case ({push, pop})
            2'b10:   s_nxt.count = s_r.count + 1'b1;
            2'b01:   s_nxt.count = s_r.count - 1'b1;
            default: s_nxt.count = s_r.count;
        endcase
    end

    // State register.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==============================================================
    // A full buffer refuses data; occupancy grows by one on a push without a pop.
    property p_full_refuses;
        @(posedge sys_clk) disable iff (sys_rst)
        (s_r.count == (AW+1)'(DEPTH)) |-> !in_ready;
    endproperty
    a_full_refuses: assert property (p_full_refuses)
        else $error("fifo accepts data while full");

    property p_count_push;
        @(posedge sys_clk) disable iff (sys_rst)
        (push && !pop) |=> (s_r.count == $past(s_r.count) + 1'b1);
    endproperty
    a_count_push: assert property (p_count_push)
        else $error("fifo count did not grow on push");

endmodule : sample_fifo
`default_nettype wire

//--- hdl/fir_config_and_gain_trim.sv
`timescale 1ns/10ps
`default_nettype none
module fir_config_and_gain_trim #(
    parameter int FIFO_DEPTH = fir_cfg_pkg::FIFO_DEPTH
) (
    input  wire logic                     sys_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [15:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic                          pready,
    output logic      [31:0]              prdata,
    output logic                          pslverr,
    input  wire logic [4:0]               fuse_gain_a0,
    input  wire logic [4:0]               fuse_gain_a1,
    input  wire logic [4:0]               fuse_gain_b0,
    input  wire logic [4:0]               fuse_gain_b1,
    input  wire logic [4:0]               fuse_gain_b1_dual,
    input  wire logic signed [11:0]       coef_a_center,
    input  wire logic signed [11:0]       coef_a_side,
    input  wire logic signed [11:0]       coef_b_center,
    input  wire logic signed [11:0]       coef_b_side,
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic signed [11:0]       in_a,
    input  wire logic signed [11:0]       in_b,
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic      [11:0]              out_a,
    output logic      [11:0]              out_b,
    output logic                          serial_link_enable,
    output logic      [4:0]               gain_trim_a0,
    output logic      [4:0]               gain_trim_a1,
    output logic      [4:0]               gain_trim_b0,
    output logic      [4:0]               gain_trim_b1,
    output logic      [4:0]               gain_trim_b1_dual
);
    typedef enum logic {ST_LOAD, ST_RUN} boot_t;

    typedef struct packed {
        boot_t              boot;
        logic [4:0]         g_a0;
        logic [4:0]         g_a1;
        logic [4:0]         g_b0;
        logic [4:0]         g_b1;
        logic [4:0]         g_b1_dual;
        logic [6:0]         cfg;
        logic               link_en;
        logic [31:0]        rdata;
        logic               slverr;
        logic signed [11:0] a_p;
        logic signed [11:0] a_pp;
        logic signed [11:0] b_p;
        logic signed [11:0] b_pp;
    } state_t;

    state_t             s_r;
    state_t             s_nxt;
    logic [13:0]        idx;
    logic               setup;
    logic               filter_on;
    logic               share;
    logic               merge;
    logic [2:0]         scw;
    logic signed [11:0] b_center_use;
    logic signed [11:0] b_side_use;
    logic signed [11:0] y_a;
    logic signed [11:0] y_b;
    logic [23:0]        push_data;
    logic               fifo_in_ready;
    logic               push;
    logic [23:0]        fifo_out;

    // ==============================================================
    // Helpers.

    // One equalizer output: centre tap plus weighted side pair.
    function automatic logic signed [11:0] eq_tap(
        input logic signed [11:0] c_ctr,
        input logic signed [11:0] c_side,
        input logic signed [11:0] x_c,
        input logic signed [11:0] x_l,
        input logic signed [11:0] x_r,
        input logic [2:0]         w
    );
        logic signed [12:0] pair;
        logic signed [35:0] acc;
        logic signed [35:0] q;
        pair = 13'(x_l) + 13'(x_r);
        acc  = (36'(c_ctr * x_c) <<< fir_cfg_pkg::CENTER_SHIFT)
             + (36'(c_side * pair) <<< w);
        q    = acc >>> fir_cfg_pkg::SIDE_EXP;
        if (q > 36'sh7ff) begin
            eq_tap = 12'sh7ff;
        end else if (q < -36'sh800) begin
            eq_tap = 12'sh800;
        end else begin
            eq_tap = q[11:0];
        end
    endfunction : eq_tap

    // True when the index names a register of this block.
    function automatic logic mapped(input logic [13:0] i);
        mapped = (i == fir_cfg_pkg::IDX_GAIN_B1_DUAL)
              || (i == fir_cfg_pkg::IDX_GAIN_A0_SINGLE)
              || (i == fir_cfg_pkg::IDX_GAIN_A1_SINGLE)
              || (i == fir_cfg_pkg::IDX_GAIN_B0_SINGLE)
              || (i == fir_cfg_pkg::IDX_GAIN_B1_SINGLE)
              || (i == fir_cfg_pkg::IDX_FIR_CFG)
              || (i == fir_cfg_pkg::IDX_LINK_CTRL)
              || (i == fir_cfg_pkg::IDX_STATUS);
    endfunction : mapped

    // ==============================================================
    // Configuration decode and coefficient routing.
    assign idx       = paddr[15:2];
    assign setup     = psel && !penable && (s_r.boot == ST_RUN);
    assign share     = s_r.cfg[fir_cfg_pkg::CFG_SHARE_BIT];
    assign merge     = s_r.cfg[fir_cfg_pkg::CFG_MERGE_BIT];
    assign scw       = s_r.cfg[fir_cfg_pkg::CFG_SCW_MSB:
                               fir_cfg_pkg::CFG_SCW_LSB];
    assign filter_on = (s_r.cfg[fir_cfg_pkg::CFG_MODE_MSB:
                                fir_cfg_pkg::CFG_MODE_LSB]
                        == fir_cfg_pkg::MODE_ON);

    // Channel B borrows the A set when shared or merged.
    assign b_center_use = (share || merge) ? coef_a_center
                                           : coef_b_center;
    assign b_side_use   = (share || merge) ? coef_a_side
                                           : coef_b_side;

    // Filter outputs; merged order is a0 b0 a1 b1 on one stream.
    always_comb begin
        if (merge) begin
            y_a = eq_tap(coef_a_center, coef_a_side, in_a, s_r.b_p,
                         in_b, scw);
            y_b = eq_tap(coef_a_center, coef_a_side, s_r.b_p, s_r.a_p,
                         in_a, scw);
        end else begin
            y_a = eq_tap(coef_a_center, coef_a_side, s_r.a_p, s_r.a_pp,
                         in_a, scw);
            y_b = eq_tap(b_center_use, b_side_use, s_r.b_p, s_r.b_pp,
                         in_b, scw);
        end
    end

    // Bypass keeps samples untouched while the filter is off.
    assign push_data = filter_on ? {y_a, y_b} : {in_a, in_b};
    assign push      = in_valid && fifo_in_ready;
    assign in_ready  = fifo_in_ready;

    // ==============================================================
    // Output buffer; a stalled consumer stalls the sample input.
    sample_fifo #(
        .WIDTH (24),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .in_valid  (in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (fifo_out)
    );
    assign out_a = fifo_out[23:12];
    assign out_b = fifo_out[11:0];

    // ==============================================================
    // Bus answers and register outputs.
    assign pready             = psel && penable && (s_r.boot == ST_RUN);
    assign prdata             = s_r.rdata;
    assign pslverr            = pready && s_r.slverr;
    assign serial_link_enable = s_r.link_en;
    assign gain_trim_a0       = s_r.g_a0;
    assign gain_trim_a1       = s_r.g_a1;
    assign gain_trim_b0       = s_r.g_b0;
    assign gain_trim_b1       = s_r.g_b1;
    assign gain_trim_b1_dual  = s_r.g_b1_dual;

    // Next state: fuse load, register access and sample history.
    always_comb begin
        s_nxt = s_r;
        if (s_r.boot == ST_LOAD) begin
            s_nxt.g_a0      = fuse_gain_a0;
            s_nxt.g_a1      = fuse_gain_a1;
            s_nxt.g_b0      = fuse_gain_b0;
            s_nxt.g_b1      = fuse_gain_b1;
            s_nxt.g_b1_dual = fuse_gain_b1_dual;
            s_nxt.boot      = ST_RUN;
        end
        // Setup phase: latch read data and decide on refusal.
        if (setup) begin
            s_nxt.rdata  = '0;
            s_nxt.slverr = !mapped(idx)
                        || (pwrite && idx == fir_cfg_pkg::IDX_STATUS)
                        || (pwrite && s_r.link_en
                            && idx == fir_cfg_pkg::IDX_FIR_CFG);
            case (idx)
                fir_cfg_pkg::IDX_GAIN_B1_DUAL:
                    s_nxt.rdata[4:0] = s_r.g_b1_dual;
                fir_cfg_pkg::IDX_GAIN_A0_SINGLE:
                    s_nxt.rdata[4:0] = s_r.g_a0;
                fir_cfg_pkg::IDX_GAIN_A1_SINGLE:
                    s_nxt.rdata[4:0] = s_r.g_a1;
                fir_cfg_pkg::IDX_GAIN_B0_SINGLE:
                    s_nxt.rdata[4:0] = s_r.g_b0;
                fir_cfg_pkg::IDX_GAIN_B1_SINGLE:
                    s_nxt.rdata[4:0] = s_r.g_b1;
                fir_cfg_pkg::IDX_FIR_CFG:
                    s_nxt.rdata[6:0] = s_r.cfg;
                fir_cfg_pkg::IDX_LINK_CTRL:
                    s_nxt.rdata[0] = s_r.link_en;
                fir_cfg_pkg::IDX_STATUS:
                    s_nxt.rdata[1:0] = {filter_on, s_r.boot == ST_RUN};
                default:
                    s_nxt.rdata = '0;
            endcase
        end
        // Access phase: writes land only when not refused.
        if (pready && pwrite && !s_r.slverr) begin
            case (idx)
                fir_cfg_pkg::IDX_GAIN_B1_DUAL:
                    s_nxt.g_b1_dual = pwdata[4:0];
                fir_cfg_pkg::IDX_GAIN_A0_SINGLE:
                    s_nxt.g_a0 = pwdata[4:0];
                fir_cfg_pkg::IDX_GAIN_A1_SINGLE:
                    s_nxt.g_a1 = pwdata[4:0];
                fir_cfg_pkg::IDX_GAIN_B0_SINGLE:
                    s_nxt.g_b0 = pwdata[4:0];
                fir_cfg_pkg::IDX_GAIN_B1_SINGLE:
                    s_nxt.g_b1 = pwdata[4:0];
                fir_cfg_pkg::IDX_FIR_CFG:
                    s_nxt.cfg = pwdata[6:0];
                fir_cfg_pkg::IDX_LINK_CTRL:
                    s_nxt.link_en = pwdata[0];
                default:
                    s_nxt.link_en = s_r.link_en;
            endcase
        end
        // Sample history advances on each accepted beat.
        if (push) begin
            s_nxt.a_pp = s_r.a_p;
            s_nxt.a_p  = in_a;
            s_nxt.b_pp = s_r.b_p;
            s_nxt.b_p  = in_b;
        end
    end

    // State register; the fuse copy happens at the first clocked edge.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r           <= '0;
            s_r.boot      <= ST_LOAD;
            s_r.cfg       <= fir_cfg_pkg::CFG_RESET;
            s_r.g_a0      <= fir_cfg_pkg::GAIN_RESET;
            s_r.g_a1      <= fir_cfg_pkg::GAIN_RESET;
            s_r.g_b0      <= fir_cfg_pkg::GAIN_RESET;
            s_r.g_b1      <= fir_cfg_pkg::GAIN_RESET;
            s_r.g_b1_dual <= fir_cfg_pkg::GAIN_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==============================================================
    // Checks.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_setup;
        psel && !penable && (s_r.boot == ST_RUN);
    endsequence
    sequence s_cfg_write;
        pready && pwrite && idx == fir_cfg_pkg::IDX_FIR_CFG;
    endsequence

    property p_apb_ready;
        s_setup ##1 (psel && penable) |-> pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready)
        else $error("access phase not answered at once");

    property p_share;
        (share && !merge) |-> (b_center_use == coef_a_center
                               && b_side_use == coef_a_side);
    endproperty
    a_share: assert property (p_share)
        else $error("shared B path not on A coefficients");

    property p_merge_a_taps;
        merge |-> (b_center_use == coef_a_center
                   && b_side_use == coef_a_side);
    endproperty
    a_merge_a_taps: assert property (p_merge_a_taps)
        else $error("merged filter not on A coefficients");

    property p_cfg_locked;
        (s_cfg_write and s_r.link_en) |=> $stable(s_r.cfg);
    endproperty
    a_cfg_locked: assert property (p_cfg_locked)
        else $error("filter configuration changed with link on");

    property p_cfg_mode;
        (s_cfg_write and !s_r.link_en and pwdata[1:0] == 2'h2)
            |=> filter_on && scw == $past(pwdata[4:2]);
    endproperty
    a_cfg_mode: assert property (p_cfg_mode)
        else $error("mode 2 write did not enable filter");

    property p_bypass;
        (push && !filter_on) |-> push_data == {in_a, in_b};
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("disabled filter altered samples");

    // Reset still stands at the releasing edge, so no attempt starts there.
    property p_fuse_load;
        (s_r.boot == ST_LOAD && !sys_rst)
            |=> (gain_trim_a0 == $past(fuse_gain_a0)
            && gain_trim_b1_dual == $past(fuse_gain_b1_dual));
    endproperty
    a_fuse_load: assert property (p_fuse_load)
        else $error("gain trim not taken from fuse");

    property p_gain_reserved;
        (s_setup and idx == fir_cfg_pkg::IDX_GAIN_A0_SINGLE)
            |=> prdata[31:5] == 27'h0000000;
    endproperty
    a_gain_reserved: assert property (p_gain_reserved)
        else $error("gain trim reserved bits read nonzero");

    property p_gain_separate;
        (pready && pwrite && idx == fir_cfg_pkg::IDX_GAIN_B1_SINGLE)
            |=> $stable(s_r.g_b1_dual);
    endproperty
    a_gain_separate: assert property (p_gain_separate)
        else $error("single write touched dual gain trim");

endmodule : fir_config_and_gain_trim
`default_nettype wire

//--- bench/fir_config_and_gain_trim_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module fir_config_and_gain_trim_tb_top;
    // ==========================================================
    // Stimulus signals and bench state.
    logic                sys_clk = 1'b0;
    logic                sys_rst = 1'b1;
    logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0]         paddr = 16'h0000;
    logic [31:0]         pwdata = 32'h0, prdata, lfsr = 32'h5cd11026;
    logic                pready, pslverr, in_ready, out_valid, link;
    logic [4:0]          fz [5], go [5];
    logic signed [11:0]  ca_c = '0, ca_s = '0, cb_c = '0, cb_s = '0;
    logic signed [11:0]  in_a = '0, in_b = '0, ha1 = '0, ha2 = '0;
    logic signed [11:0]  hb1 = '0, hb2 = '0;
    logic [1:0]          sc = 2'h0;
    logic                in_valid = 1'b0, out_ready = 1'b0, hold = 1'b0;
    logic [11:0]         out_a, out_b;
    logic [6:0]          cfg = 7'h00;
    logic [31:0]         wv [5];
    logic [32:0]         aq [$];
    logic [23:0]         sq [$];
    int                  error_cnt = 0, n_compared = 0;
    localparam logic [13:0] gidx [5] = '{fir_cfg_pkg::IDX_GAIN_A0_SINGLE,
        fir_cfg_pkg::IDX_GAIN_A1_SINGLE, fir_cfg_pkg::IDX_GAIN_B0_SINGLE,
        fir_cfg_pkg::IDX_GAIN_B1_SINGLE, fir_cfg_pkg::IDX_GAIN_B1_DUAL};

    fir_config_and_gain_trim DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .fuse_gain_a0(fz[0]), .fuse_gain_a1(fz[1]),
        .fuse_gain_b0(fz[2]), .fuse_gain_b1(fz[3]),
        .fuse_gain_b1_dual(fz[4]), .coef_a_center(ca_c),
        .coef_a_side(ca_s), .coef_b_center(cb_c), .coef_b_side(cb_s),
        .in_valid(in_valid), .in_ready(in_ready), .in_a(in_a),
        .in_b(in_b), .out_valid(out_valid), .out_ready(out_ready),
        .out_a(out_a), .out_b(out_b), .serial_link_enable(link),
        .gain_trim_a0(go[0]), .gain_trim_a1(go[1]), .gain_trim_b0(go[2]),
        .gain_trim_b1(go[3]), .gain_trim_b1_dual(go[4]));

    // The clock toggles every half period of 2 ns.
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Helpers: random source, comparison, verdict, reference.
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
        return lfsr;
    endfunction : rnd

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task automatic fail();
        error_cnt++;
        report_and_stop();
    endtask : fail

    // One tap set: centre weight 2^-11, sides 2^(w-16), saturated.
    function automatic logic [11:0] fo(input logic signed [11:0] cc, cs,
        xc, xl, xr, input logic [2:0] w);
        longint acc;
        acc = ((longint'(cc) * longint'(xc)) <<< 5)
            + ((longint'(cs) * (longint'(xl) + longint'(xr))) <<< w);
        acc = acc >>> 16;
        if (acc > 2047) acc = 2047;
        else if (acc < -2048) acc = -2048;
        return acc[11:0];
    endfunction : fo

    // One APB transfer; the expected answer is queued first.
    task automatic apb(logic w, logic [13:0] idx, logic [31:0] wd,
        logic ee, logic [31:0] ed);
        int n;
        aq.push_back({ee, ed});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (pready) break;
        end
        if (n == 50) fail();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    // One sample beat; the expected output is queued at handshake.
    task automatic push();
        logic signed [11:0] a, b, ea, eb, k1, k2;
        logic [31:0]        r;
        int                 n;
        r = rnd();
        a = r[11:0];
        b = r[27:16];
        in_valid <= 1'b1;
        in_a <= a;
        in_b <= b;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (in_ready) break;
        end
        if (n == 50) fail();
        k1 = cfg[6] ? ca_c : cb_c;
        k2 = cfg[6] ? ca_s : cb_s;
        if (cfg[1:0] != 2'h2) begin
            ea = a;
            eb = b;
        end else if (cfg[5]) begin
            ea = fo(ca_c, ca_s, a, hb1, b, cfg[4:2]);
            eb = fo(ca_c, ca_s, hb1, ha1, a, cfg[4:2]);
        end else begin
            ea = fo(ca_c, ca_s, ha1, ha2, a, cfg[4:2]);
            eb = fo(k1, k2, hb1, hb2, b, cfg[4:2]);
        end
        sq.push_back({ea, eb});
        ha2 = ha1;
        ha1 = a;
        hb2 = hb1;
        hb1 = b;
    endtask : push

    // The downstream side stalls at random unless held off.
    // The random source only moves per beat, so every fourth cycle grants.
    always @(posedge sys_clk) begin
        sc <= sc + 2'h1;
        out_ready <= !hold && (lfsr[5] || sc == 2'h3);
    end

    // Compares each finished APB transfer with its queued answer.
    always @(posedge sys_clk) begin
        if (psel && penable && pready) begin
            chk("pslverr", {31'h0, pslverr}, {31'h0, aq[0][32]});
            if (!pwrite) chk("prdata", prdata, aq[0][31:0]);
            void'(aq.pop_front());
        end
    end

    // Compares each delivered sample beat with its queued value.
    always @(posedge sys_clk) begin
        if (out_valid && out_ready) begin
            if (sq.size() == 0) chk("spare beat", 32'h1, 32'h0);
            else begin
                chk("out_a", {20'h0, out_a}, {20'h0, sq[0][23:12]});
                chk("out_b", {20'h0, out_b}, {20'h0, sq[0][11:0]});
                void'(sq.pop_front());
            end
        end
    end

    // Main sequence: registers first, then the sample path.
    initial begin
        int          i, j;
        logic [31:0] r;
        logic [6:0]  c;
        for (i = 0; i < 5; i++) begin
            r = rnd();
            fz[i] = r[4:0];
        end
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        for (i = 0; i < 5; i++) apb(0, gidx[i], 0, 0, {27'h0, fz[i]});
        apb(0, fir_cfg_pkg::IDX_FIR_CFG, 0, 0, 0);
        for (i = 0; i < 5; i++) begin
            wv[i] = rnd();
            apb(1, gidx[i], wv[i], 0, 0);
        end
        for (i = 0; i < 5; i++) begin
            apb(0, gidx[i], 0, 0, {27'h0, wv[i][4:0]});
            chk("trim", {27'h0, go[i]}, {27'h0, wv[i][4:0]});
        end
        apb(0, 14'h0000, 0, 1, 0);
        apb(1, fir_cfg_pkg::IDX_LINK_CTRL, 1, 0, 0);
        chk("link", {31'h0, link}, 32'h1);
        apb(1, fir_cfg_pkg::IDX_FIR_CFG, 32'h66, 1, 0);
        apb(0, fir_cfg_pkg::IDX_FIR_CFG, 0, 0, 0);
        apb(1, fir_cfg_pkg::IDX_LINK_CTRL, 0, 0, 0);
        for (i = 0; i < 4; i++) begin
            r = rnd();
            ca_c <= r[11:0];
            ca_s <= r[27:16];
            r = rnd();
            cb_c <= r[11:0];
            cb_s <= r[27:16];
            r = rnd();
            c = {i == 2, i == 3, 3'(r[7:0] % 7), (i == 0) ? 2'h0 : 2'h2};
            apb(1, fir_cfg_pkg::IDX_FIR_CFG, {25'h0, c}, 0, 0);
            cfg = c;
            apb(0, fir_cfg_pkg::IDX_FIR_CFG, 0, 0, {25'h0, c});
            hold = 1'b1;
            for (j = 0; j < 8; j++) push();
            in_valid <= 1'b0;
            @(posedge sys_clk);
            chk("in_ready", {31'h0, in_ready}, 32'h0);
            hold = 1'b0;
            for (j = 0; j < 8; j++) push();
            in_valid <= 1'b0;
            for (j = 0; j < 300 && sq.size() > 0; j++) @(posedge sys_clk);
            if (sq.size() > 0) fail();
        end
        report_and_stop();
    end
endmodule : fir_config_and_gain_trim_tb_top
`default_nettype wire
